/* File: audio_path_pkg.sv */
/*
 Shared constants for the playback path control block: register
 addresses, field positions, reset values and gain code limits.
 Assumes a 7-bit register address and 9-bit register data word.
*/
package audio_path_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [6:0] ADDR_LEFT_PHONES = 7'h02;
	localparam logic [6:0] ADDR_RIGHT_PHONES = 7'h03;
	localparam logic [6:0] ADDR_ANALOGUE_PATH = 7'h04;
	localparam logic [6:0] ADDR_DIGITAL_PATH = 7'h05;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h0F;

	// ==========================================================
	// Field positions
	localparam int GAIN_LSB = 0;
	localparam int ZERO_CROSS_BIT = 7;
	localparam int LOAD_BOTH_BIT = 8;
	localparam int BYPASS_BIT = 3;
	localparam int DAC_ROUTE_BIT = 4;
	localparam int SIDETONE_BIT = 5;
	localparam int HPF_DISABLE_BIT = 0;
	localparam int DEEMPH_LSB = 1;
	localparam int SOFT_MUTE_BIT = 3;
	localparam int OFFSET_HOLD_BIT = 4;

	// ==========================================================
	// Reset values
	localparam logic [6:0] GAIN_RESET = 7'h79;
	localparam logic ZERO_CROSS_RESET = 1'b0;
	localparam logic BYPASS_RESET = 1'b1;
	localparam logic DAC_ROUTE_RESET = 1'b0;
	localparam logic SIDETONE_RESET = 1'b0;
	localparam logic HPF_DISABLE_RESET = 1'b0;
	localparam logic [1:0] DEEMPH_RESET = 2'h0;
	localparam logic SOFT_MUTE_RESET = 1'b1;
	localparam logic OFFSET_HOLD_RESET = 1'b0;

	// ==========================================================
	// Gain codes
	localparam logic [6:0] GAIN_MUTE_LIMIT = 7'h30;
	localparam logic [6:0] GAIN_MAX = 7'h7F;

	typedef enum logic [1:0] {
		DEEMPH_OFF = 2'b00,
		DEEMPH_32K = 2'b01,
		DEEMPH_44K1 = 2'b10,
		DEEMPH_48K = 2'b11
	} deemph_t;

endpackage

/* File: phones_channel.sv */
/*
 One headphone channel: holds the applied gain and any gain waiting
 for a zero crossing. Assumes near_ground is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module phones_channel #(
	parameter int GAIN_WIDTH = 7
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic soft_rst,
	input wire logic load,
	input wire logic [GAIN_WIDTH-1:0] load_gain,
	input wire logic load_zc,
	input wire logic near_ground,
	output logic [GAIN_WIDTH-1:0] gain,
	output logic zero_cross_enable,
	output logic pending,
	output logic muted
);

	logic [GAIN_WIDTH-1:0] pending_gain;

	if (GAIN_WIDTH != 7) begin
		$error("phones_channel supports a 7-bit gain code only");
	end

	// ==========================================================
	// Gain update
	// No timeout on the wait: a steady offset may hold it forever
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gain <= audio_path_pkg::GAIN_RESET;
			zero_cross_enable <= audio_path_pkg::ZERO_CROSS_RESET;
			pending <= 1'b0;
			pending_gain <= audio_path_pkg::GAIN_RESET;
			muted <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst) begin
				gain <= audio_path_pkg::GAIN_RESET;
				zero_cross_enable <= audio_path_pkg::ZERO_CROSS_RESET;
				pending <= 1'b0;
				pending_gain <= audio_path_pkg::GAIN_RESET;
				muted <= 1'b0;
			end else if (load) begin
				zero_cross_enable <= load_zc;
				if (load_zc) begin
					pending <= 1'b1;
					pending_gain <= load_gain;
				end else begin
					pending <= 1'b0;
					gain <= load_gain;
					muted <= load_gain < audio_path_pkg::GAIN_MUTE_LIMIT;
				end
			end else if (pending && near_ground) begin
				pending <= 1'b0;
				gain <= pending_gain;
				muted <= pending_gain < audio_path_pkg::GAIN_MUTE_LIMIT;
			end
		end
	end

	// ==========================================================
	// Checks
	apply_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !soft_rst && !load && pending && !near_ground
		|=> $stable(gain))
		else $error("Gain changed away from ground");
	direct_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !soft_rst && load && !load_zc
		|=> gain == $past(load_gain) && !pending)
		else $error("Direct gain write not applied");
	mute_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		muted == (gain < audio_path_pkg::GAIN_MUTE_LIMIT))
		else $error("Mute flag does not match gain code");

endmodule

/* File: dac_soft_mute_ramp.sv */
/*
 Soft mute ramp: a digital scale factor that steps toward zero while
 mute is asserted and back to full scale when released. Steps advance on
 sample_tick, which the audio interface provides.
*/
`timescale 1ns/1ps
module dac_soft_mute_ramp #(
	parameter int SCALE_WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic mute,
	input wire logic sample_tick,
	output logic [SCALE_WIDTH-1:0] scale,
	output logic at_mute
);

	localparam logic [SCALE_WIDTH-1:0] FULL = '1;

	if (SCALE_WIDTH < 2) begin
		$error("dac_soft_mute_ramp needs at least two scale bits");
	end

	// ==========================================================
	// Ramp; starts muted, matching the mute bit's reset value
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scale <= '0;
			at_mute <= 1'b1;
		end else if (clk_en && sample_tick) begin
			if (mute && scale != '0) begin
				scale <= scale - 1'b1;
				at_mute <= scale == SCALE_WIDTH'(1);
			end else if (!mute && scale != FULL) begin
				scale <= scale + 1'b1;
				at_mute <= 1'b0;
			end
		end
	end

	ramp_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && sample_tick && mute && scale != '0
		|=> scale == $past(scale) - 1'b1)
		else $error("Soft mute did not step down by one");

endmodule

/* File: audio_output_path_control.sv */
/*
 Playback path control registers: headphone gains with zero-cross
 gating and both-channel load, line output source selects, DAC
 de-emphasis and soft mute, ADC offset hold. Register writes arrive
 as a decoded address/data strobe from the serial control logic.
 All inputs are synchronous to ref_clk.
*/
// Notes on behaviour
// - Offset hold keeps last dc offset once filter off; else clear it.
// - ADC filter type follows sample rate; no software filter-type bit.
// - DAC filters take 24-bit samples to oversampled converter data.
// - Two-bit de-emphasis: 11 48k, 10 44.1k, 01 32k, 00 off; resets 00.
// - Soft mute ramps DAC data down gradually; resets to muted.
// - Line output sums DAC, line bypass and sidetone when each selected.
// - DAC route bit adds DAC into line sum when set; resets clear.
// - Bypass bit adds line input to sum; resets set.
// - Sidetone bit adds microphone to sum when set; resets clear.
// - Seven-bit gain, 1 dB steps, +6 dB at 7F down to -73 dB at 30.
// - Gain codes 00 to 2F mute that channel alone.
// - Both headphone gains reset to 79, which is 0 dB.
// - Zero-cross enable is bit 7 of each headphone register; resets 0.
// - Zero-cross write holds new gain until input is near ground.
// - Zero-cross wait never times out.
// - Write with zero-cross clear applies gain at once, dropping pending.
// - Bit 8 on left write loads both channels.
// - Bit 8 on right write loads both channels.
// - Left headphone register at address 02, right at 03.
`timescale 1ns/1ps
module audio_output_path_control #(
	parameter int SAMPLE_WIDTH = 24,
	parameter int RAMP_WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic reg_write,
	input wire logic [6:0] reg_addr,
	input wire logic [8:0] reg_data,
	input wire logic [3:0] sample_rate_code,
	input wire logic sample_tick,
	input wire logic left_near_ground,
	input wire logic right_near_ground,
	input wire logic [SAMPLE_WIDTH-1:0] dc_offset_in,
	input wire logic [SAMPLE_WIDTH-1:0] dac_sample_in,
	output logic [6:0] left_phones_gain,
	output logic [6:0] right_phones_gain,
	output logic left_zero_cross_enable,
	output logic right_zero_cross_enable,
	output logic left_phones_mute,
	output logic right_phones_mute,
	output logic left_gain_pending,
	output logic right_gain_pending,
	output logic line_bypass,
	output logic dac_route_select,
	output logic sidetone_select,
	output logic adc_highpass_disable,
	output logic offset_hold,
	output logic [1:0] deemphasis_select,
	output logic dac_soft_mute,
	output logic adc_filter_alt,
	output logic [SAMPLE_WIDTH-1:0] offset_subtract,
	output logic [SAMPLE_WIDTH-1:0] dac_sample_out,
	output logic dac_at_mute
);

	// ==========================================================
	// Checks on parameters
	if (SAMPLE_WIDTH != 24) begin
		$error("DAC path processes 24-bit samples only");
	end
	if (RAMP_WIDTH < 2 || RAMP_WIDTH > 16) begin
		$error("RAMP_WIDTH must be 2 to 16");
	end

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [6:0] addr,
		input logic [6:0] target);
		hit = addr == target;
	endfunction

	logic wr_left;
	logic wr_right;
	logic wr_analogue;
	logic wr_digital;
	logic soft_rst;
	logic load_left;
	logic load_right;
	logic load_both_channels;

	always_comb begin
		wr_left = reg_write && hit(reg_addr, audio_path_pkg::ADDR_LEFT_PHONES);
		wr_right = reg_write && hit(reg_addr, audio_path_pkg::ADDR_RIGHT_PHONES);
		wr_analogue = reg_write && hit(reg_addr, audio_path_pkg::ADDR_ANALOGUE_PATH);
		wr_digital = reg_write && hit(reg_addr, audio_path_pkg::ADDR_DIGITAL_PATH);
		// Software reset: all-zero write to the reset register
		soft_rst = reg_write && hit(reg_addr, audio_path_pkg::ADDR_SOFT_RESET)
			&& reg_data == 9'h000;
		load_both_channels = reg_data[audio_path_pkg::LOAD_BOTH_BIT];
		load_left = wr_left || (wr_right && load_both_channels);
		load_right = wr_right || (wr_left && load_both_channels);
	end

	// ==========================================================
	// Headphone channels
	logic [6:0] left_gain_now;
	logic [6:0] right_gain_now;
	logic left_zc_now;
	logic right_zc_now;
	logic left_pend_now;
	logic right_pend_now;
	logic left_mute_now;
	logic right_mute_now;

	phones_channel #(
		.GAIN_WIDTH(7)
	) left_channel (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.soft_rst(soft_rst),
		.load(load_left),
		.load_gain(reg_data[6:0]),
		.load_zc(reg_data[audio_path_pkg::ZERO_CROSS_BIT]),
		.near_ground(left_near_ground),
		.gain(left_gain_now),
		.zero_cross_enable(left_zc_now),
		.pending(left_pend_now),
		.muted(left_mute_now)
	);

	phones_channel #(
		.GAIN_WIDTH(7)
	) right_channel (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.soft_rst(soft_rst),
		.load(load_right),
		.load_gain(reg_data[6:0]),
		.load_zc(reg_data[audio_path_pkg::ZERO_CROSS_BIT]),
		.near_ground(right_near_ground),
		.gain(right_gain_now),
		.zero_cross_enable(right_zc_now),
		.pending(right_pend_now),
		.muted(right_mute_now)
	);

	// Retimed so that every output leaves a flip-flop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			left_phones_gain <= audio_path_pkg::GAIN_RESET;
			right_phones_gain <= audio_path_pkg::GAIN_RESET;
			left_zero_cross_enable <= audio_path_pkg::ZERO_CROSS_RESET;
			right_zero_cross_enable <= audio_path_pkg::ZERO_CROSS_RESET;
			left_gain_pending <= 1'b0;
			right_gain_pending <= 1'b0;
			left_phones_mute <= 1'b0;
			right_phones_mute <= 1'b0;
		end else if (clk_en) begin
			left_phones_gain <= left_gain_now;
			right_phones_gain <= right_gain_now;
			left_zero_cross_enable <= left_zc_now;
			right_zero_cross_enable <= right_zc_now;
			left_gain_pending <= left_pend_now;
			right_gain_pending <= right_pend_now;
			left_phones_mute <= left_mute_now;
			right_phones_mute <= right_mute_now;
		end
	end

	// ==========================================================
	// Analogue path control
	// Silencing the line output is the host's job: it must mute the
	// DAC and clear both analogue paths; nothing here forces it.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			line_bypass <= audio_path_pkg::BYPASS_RESET;
			dac_route_select <= audio_path_pkg::DAC_ROUTE_RESET;
			sidetone_select <= audio_path_pkg::SIDETONE_RESET;
		end else if (clk_en) begin
			if (soft_rst) begin
				line_bypass <= audio_path_pkg::BYPASS_RESET;
				dac_route_select <= audio_path_pkg::DAC_ROUTE_RESET;
				sidetone_select <= audio_path_pkg::SIDETONE_RESET;
			end else if (wr_analogue) begin
				line_bypass <= reg_data[audio_path_pkg::BYPASS_BIT];
				dac_route_select <= reg_data[audio_path_pkg::DAC_ROUTE_BIT];
				sidetone_select <= reg_data[audio_path_pkg::SIDETONE_BIT];
			end
		end
	end

	// ==========================================================
	// Digital path control
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			adc_highpass_disable <= audio_path_pkg::HPF_DISABLE_RESET;
			deemphasis_select <= audio_path_pkg::DEEMPH_RESET;
			dac_soft_mute <= audio_path_pkg::SOFT_MUTE_RESET;
			offset_hold <= audio_path_pkg::OFFSET_HOLD_RESET;
		end else if (clk_en) begin
			if (soft_rst) begin
				adc_highpass_disable <= audio_path_pkg::HPF_DISABLE_RESET;
				deemphasis_select <= audio_path_pkg::DEEMPH_RESET;
				dac_soft_mute <= audio_path_pkg::SOFT_MUTE_RESET;
				offset_hold <= audio_path_pkg::OFFSET_HOLD_RESET;
			end else if (wr_digital) begin
				adc_highpass_disable <=
					reg_data[audio_path_pkg::HPF_DISABLE_BIT];
				deemphasis_select <=
					reg_data[audio_path_pkg::DEEMPH_LSB +: 2];
				dac_soft_mute <= reg_data[audio_path_pkg::SOFT_MUTE_BIT];
				offset_hold <= reg_data[audio_path_pkg::OFFSET_HOLD_BIT];
			end
		end
	end

	// ==========================================================
	// ADC dc offset: tracks while filter on, frozen or cleared when off
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			offset_subtract <= '0;
		end else if (clk_en) begin
			if (!adc_highpass_disable)
				offset_subtract <= dc_offset_in;
			else if (!offset_hold)
				offset_subtract <= '0;
		end
	end

	// Filter type follows the sample rate; no register bit for it.
	// Codes with top bit set pick the alternate response.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			adc_filter_alt <= 1'b0;
		else if (clk_en)
			adc_filter_alt <= sample_rate_code[3];
	end

	// ==========================================================
	// DAC soft mute and 24-bit sample scaling
	logic [RAMP_WIDTH-1:0] ramp_scale;
	logic ramp_at_mute;
	logic signed [SAMPLE_WIDTH+RAMP_WIDTH:0] scaled;

	dac_soft_mute_ramp #(
		.SCALE_WIDTH(RAMP_WIDTH)
	) mute_ramp (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.mute(dac_soft_mute),
		.sample_tick(sample_tick),
		.scale(ramp_scale),
		.at_mute(ramp_at_mute)
	);

	// Full scale maps to just under unity; a one-LSB loss traded for
	// a shift instead of a divider.
	always_comb begin
		scaled = $signed({{(RAMP_WIDTH+1){dac_sample_in[SAMPLE_WIDTH-1]}},
			dac_sample_in}) * $signed({{(SAMPLE_WIDTH+1){1'b0}}, ramp_scale});
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dac_sample_out <= '0;
			dac_at_mute <= 1'b1;
		end else if (clk_en) begin
			// 24 bits kept from the product; its low RAMP_WIDTH bits are dropped
			dac_sample_out <= scaled[RAMP_WIDTH +: SAMPLE_WIDTH];
			dac_at_mute <= ramp_at_mute;
		end
	end

	// ==========================================================
	// Checks
	both_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_left && reg_data[8] && !reg_data[7]
		|=> ##1 right_phones_gain == $past(reg_data[6:0], 2))
		else $error("Left write with load-both missed right channel");
	right_both_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_right && reg_data[8] && !reg_data[7]
		|=> ##1 left_phones_gain == $past(reg_data[6:0], 2))
		else $error("Right write with load-both missed left channel");
	single_load_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_left && !reg_data[8] && !right_pend_now
		&& !right_near_ground |=> $stable(right_gain_now))
		else $error("Right channel changed on left-only write");
	path_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_analogue |=> line_bypass == $past(reg_data[3])
		&& dac_route_select == $past(reg_data[4]))
		else $error("Analogue path bits not stored");
	offset_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && adc_highpass_disable && !offset_hold
		|=> offset_subtract == '0)
		else $error("Offset not cleared without hold");
	offset_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && adc_highpass_disable && offset_hold
		|=> $stable(offset_subtract))
		else $error("Held offset changed");
	deemph_store_a: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_digital |=> deemphasis_select == $past(reg_data[2:1]))
		else $error("De-emphasis field not stored");
	// Register views, one edge after the write for path bits, two for headphone outputs, when the clock runs
	mute_store_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && wr_digital
		|=> dac_soft_mute == $past(reg_data[audio_path_pkg::SOFT_MUTE_BIT]))
		else $error("Soft mute bit not stored");
	route_store_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && wr_analogue
		|=> dac_route_select
		== $past(reg_data[audio_path_pkg::DAC_ROUTE_BIT]))
		else $error("DAC route bit not stored");
	sidetone_store_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && wr_analogue
		|=> sidetone_select
		== $past(reg_data[audio_path_pkg::SIDETONE_BIT]))
		else $error("Sidetone bit not stored");
	filter_follow_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en
		|=> adc_filter_alt == $past(sample_rate_code[3]))
		else $error("Filter type does not follow sample rate");
	soft_reset_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && soft_rst ##1 clk_en
		|=> left_phones_gain == audio_path_pkg::GAIN_RESET
		&& right_phones_gain == audio_path_pkg::GAIN_RESET)
		else $error("Soft reset did not restore gains");
	zero_cross_store_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && wr_left && !reg_data[8] ##1 clk_en
		|=> left_zero_cross_enable == $past(reg_data[7], 2))
		else $error("Zero-cross enable not stored");
	pending_show_a: assert property (@(posedge ref_clk)
		disable iff (rst) clk_en && wr_left && !reg_data[8] && reg_data[7]
		##1 clk_en |=> left_gain_pending)
		else $error("Zero-cross write not held pending");
	phones_mute_a: assert property (@(posedge ref_clk)
		disable iff (rst) left_phones_mute
		== (left_phones_gain < audio_path_pkg::GAIN_MUTE_LIMIT))
		else $error("Left mute output does not match gain");

endmodule

/* File: host_model.sv */
/*
 Host controller model: issues decoded register writes.
 Assumes the block takes a write on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	output logic clk_en,
	output logic reg_write,
	output logic [6:0] reg_addr,
	output logic [8:0] reg_data
);
	// ==========================================================
	// Write cycle
	initial begin
		clk_en = 1'b1;
		reg_write = 1'b0;
		reg_addr = 7'h00;
		reg_data = 9'h000;
	end

	// en low makes a refused write; waits let headphone retime land
	task automatic write(input logic [6:0] a, input logic [8:0] d,
		input logic en);
		@(negedge ref_clk);
		clk_en = en;
		reg_write = 1'b1;
		reg_addr = a;
		reg_data = d;
		@(negedge ref_clk);
		clk_en = 1'b1;
		reg_write = 1'b0;
		// Released bus shows the inverse, not a stale copy
		reg_addr = ~a;
		reg_data = ~d;
		repeat (2) @(negedge ref_clk);
	endtask
endmodule

/* File: audio_output_path_control_tb.sv */
/*
 Self-checking bench for the playback path control registers.
 Assumes host_model drives clk_en and the write strobe, address and data; bench drives the rest.
*/
`timescale 1ns/1ps
module audio_output_path_control_tb;
	logic ref_clk, rst, clk_en, reg_write, sample_tick;
	logic left_near_ground, right_near_ground;
	logic [6:0] reg_addr, left_phones_gain, right_phones_gain;
	logic [8:0] reg_data;
	logic [3:0] sample_rate_code;
	logic [23:0] dc_offset_in, dac_sample_in, offset_subtract;
	logic [23:0] dac_sample_out;
	logic left_zero_cross_enable, right_zero_cross_enable;
	logic left_phones_mute, right_phones_mute;
	logic left_gain_pending, right_gain_pending;
	logic line_bypass, dac_route_select, sidetone_select;
	logic adc_highpass_disable, offset_hold, dac_soft_mute;
	logic adc_filter_alt, dac_at_mute;
	logic [1:0] deemphasis_select;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;

	host_model host (.ref_clk(ref_clk), .clk_en(clk_en),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_data(reg_data));

	audio_output_path_control dut (.ref_clk(ref_clk), .rst(rst),
		.clk_en(clk_en), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_data(reg_data), .sample_rate_code(sample_rate_code),
		.sample_tick(sample_tick), .left_near_ground(left_near_ground),
		.right_near_ground(right_near_ground), .dc_offset_in(dc_offset_in),
		.dac_sample_in(dac_sample_in), .left_phones_gain(left_phones_gain),
		.right_phones_gain(right_phones_gain),
		.left_zero_cross_enable(left_zero_cross_enable),
		.right_zero_cross_enable(right_zero_cross_enable),
		.left_phones_mute(left_phones_mute),
		.right_phones_mute(right_phones_mute),
		.left_gain_pending(left_gain_pending),
		.right_gain_pending(right_gain_pending), .line_bypass(line_bypass),
		.dac_route_select(dac_route_select),
		.sidetone_select(sidetone_select),
		.adc_highpass_disable(adc_highpass_disable),
		.offset_hold(offset_hold), .deemphasis_select(deemphasis_select),
		.dac_soft_mute(dac_soft_mute), .adc_filter_alt(adc_filter_alt),
		.offset_subtract(offset_subtract), .dac_sample_out(dac_sample_out),
		.dac_at_mute(dac_at_mute));

	// ==========================================================
	// Clock, timeout, verdict
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_vec(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle();
		repeat (2) @(negedge ref_clk);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			sample_tick = 1'b1;
			@(negedge ref_clk);
			sample_tick = 1'b0;
		end
		settle();
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_reset();
		cmp_vec(24'(left_phones_gain), 24'h000079);
		cmp_vec(24'(right_phones_gain), 24'h000079);
		cmp_bit(left_zero_cross_enable, 1'b0);
		cmp_bit(right_zero_cross_enable, 1'b0);
		cmp_bit(line_bypass, 1'b1);
		cmp_bit(dac_route_select, 1'b0);
		cmp_bit(sidetone_select, 1'b0);
		cmp_vec(24'(deemphasis_select), 24'h000000);
		cmp_bit(dac_soft_mute, 1'b1);
		cmp_bit(dac_at_mute, 1'b1);
	endtask

	task automatic test_line_sources();
		logic [2:0] v;
		for (int i = 0; i < 8; i++) begin
			v = 3'(i);
			host.write(7'h04, {3'h0, v, 3'h0}, 1'b1);
			cmp_bit(line_bypass, v[0]);
			cmp_bit(dac_route_select, v[1]);
			cmp_bit(sidetone_select, v[2]);
		end
	endtask

	task automatic test_digital();
		logic [1:0] d;
		for (int i = 0; i < 4; i++) begin
			d = 2'(i);
			host.write(7'h05, {6'h01, d, 1'b0}, 1'b1);
			cmp_vec(24'(deemphasis_select), 24'(d));
			cmp_bit(dac_soft_mute, 1'b1);
		end
		dc_offset_in = 24'h123456;
		settle();
		cmp_vec(offset_subtract, 24'h123456);
		host.write(7'h05, 9'h019, 1'b1);
		dc_offset_in = 24'h0ABCDE;
		settle();
		cmp_bit(offset_hold, 1'b1);
		cmp_bit(adc_highpass_disable, 1'b1);
		cmp_vec(offset_subtract, 24'h123456);
		host.write(7'h05, 9'h009, 1'b1);
		cmp_vec(offset_subtract, 24'h000000);
		sample_rate_code = 4'h8;
		settle();
		cmp_bit(adc_filter_alt, 1'b1);
		sample_rate_code = 4'h7;
		settle();
		cmp_bit(adc_filter_alt, 1'b0);
	endtask

	task automatic test_soft_mute();
		dac_sample_in = 24'h400000;
		host.write(7'h05, 9'h000, 1'b1);
		cmp_bit(dac_soft_mute, 1'b0);
		tick(256);
		cmp_bit(dac_at_mute, 1'b0);
		cmp_vec(dac_sample_out, 24'h3FC000);
		host.write(7'h05, 9'h008, 1'b1);
		tick(1);
		cmp_bit(dac_at_mute, 1'b0);
		cmp_vec(dac_sample_out, 24'h3F8000);
		tick(260);
		cmp_bit(dac_at_mute, 1'b1);
		cmp_vec(dac_sample_out, 24'h000000);
		host.write(7'h04, 9'h000, 1'b1);
		cmp_bit(line_bypass | sidetone_select, 1'b0);
	endtask

	task automatic test_gains();
		logic [6:0] a[4] = '{7'h02, 7'h03, 7'h02, 7'h03};
		logic [8:0] w[4] = '{9'h130, 9'h12F, 9'h07F, 9'h050};
		logic [6:0] el[4] = '{7'h30, 7'h2F, 7'h7F, 7'h7F};
		logic [6:0] er[4] = '{7'h30, 7'h2F, 7'h2F, 7'h50};
		for (int i = 0; i < 4; i++) begin
			host.write(a[i], w[i], 1'b1);
			cmp_vec(24'(left_phones_gain), 24'(el[i]));
			cmp_vec(24'(right_phones_gain), 24'(er[i]));
			cmp_bit(left_phones_mute, el[i] < 7'h30);
			cmp_bit(right_phones_mute, er[i] < 7'h30);
		end
	endtask

	task automatic test_zero_cross();
		host.write(7'h02, 9'h0A0, 1'b1);
		cmp_bit(left_gain_pending, 1'b1);
		cmp_bit(left_zero_cross_enable, 1'b1);
		cmp_vec(24'(left_phones_gain), 24'h00007F);
		cmp_bit(right_gain_pending, 1'b0);
		repeat (100) @(negedge ref_clk);
		cmp_bit(left_gain_pending, 1'b1);
		left_near_ground = 1'b1;
		settle();
		left_near_ground = 1'b0;
		cmp_vec(24'(left_phones_gain), 24'h000020);
		cmp_bit(left_gain_pending, 1'b0);
		host.write(7'h02, 9'h0C0, 1'b1);
		host.write(7'h02, 9'h040, 1'b1);
		cmp_vec(24'(left_phones_gain), 24'h000040);
		cmp_bit(left_gain_pending, 1'b0);
		host.write(7'h03, 9'h1C5, 1'b1);
		cmp_bit(left_zero_cross_enable, 1'b1);
		cmp_bit(left_gain_pending, 1'b1);
		left_near_ground = 1'b1;
		right_near_ground = 1'b1;
		settle();
		left_near_ground = 1'b0;
		right_near_ground = 1'b0;
		cmp_vec(24'(left_phones_gain), 24'h000045);
		cmp_vec(24'(right_phones_gain), 24'h000045);
	endtask

	task automatic test_refused();
		host.write(7'h06, 9'h008, 1'b1);
		cmp_vec(24'(left_phones_gain), 24'h000045);
		cmp_bit(line_bypass, 1'b0);
		host.write(7'h02, 9'h079, 1'b0);
		cmp_vec(24'(left_phones_gain), 24'h000045);
		host.write(7'h0F, 9'h000, 1'b1);
		cmp_vec(24'(right_phones_gain), 24'h000079);
		cmp_bit(line_bypass, 1'b1);
		cmp_bit(right_zero_cross_enable, 1'b0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		sample_tick = 1'b0;
		left_near_ground = 1'b0;
		right_near_ground = 1'b0;
		sample_rate_code = 4'h0;
		dc_offset_in = 24'h000000;
		dac_sample_in = 24'h000000;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		test_reset();
		test_line_sources();
		test_digital();
		test_soft_mute();
		test_gains();
		test_zero_cross();
		test_refused();
		give_verdict();
	end
endmodule
